// [mtd_acq.sv]
/*
  test word fifo and the acquisition sequencer with its register window.
  assumes one core_clk domain; trigger and abort pins are asynchronous,
  the register port and the section results come from core_clk logic.
*/
`timescale 1ns/1ps

// ********************************************
// circular fifo for test words
// ********************************************
module mtd_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 32,
  parameter int CW    = $clog2(DEPTH + 1)
) (
  // clock and control
  input  wire logic          core_clk,
  input  wire logic          rst,
  input  wire logic          ce,
  input  wire logic          flush,
  // filling side
  input  wire logic          in_valid,
  output logic               in_ready,
  input  wire logic [W-1:0]  in_data,
  // draining side
  output logic               out_valid,
  input  wire logic          out_ready,
  output logic      [W-1:0]  out_data,
  output logic      [CW-1:0] count
);
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem; // storage
    logic [PW-1:0]           wp;  // write index
    logic [PW-1:0]           rp;  // read index
    logic [CW-1:0]           cnt; // words held
  } mtd_fifo_st_t;

  mtd_fifo_st_t r, n;
  logic push, pop;

  assign in_ready  = (r.cnt != CW'(DEPTH));
  assign out_valid = (r.cnt != '0);
  assign out_data  = r.mem[r.rp];
  assign count     = r.cnt;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // next state: flush wins over any transfer
  always_comb begin
    n = r;
    if (push) begin
      n.mem[r.wp] = in_data;
      n.wp        = (r.wp == PW'(DEPTH - 1)) ? '0 : r.wp + 1'b1;
    end
    if (pop) begin
      n.rp = (r.rp == PW'(DEPTH - 1)) ? '0 : r.rp + 1'b1;
    end
    n.cnt = r.cnt + CW'(push) - CW'(pop);
    if (flush) begin
      n.wp  = '0;
      n.rp  = '0;
      n.cnt = '0;
    end
  end

  // register the state, frozen while ce is low
  always_ff @(posedge core_clk) begin
    if (rst) begin
      r <= '0;
    end else if (ce) begin
      r <= n;
    end
  end
endmodule : mtd_fifo

// ********************************************
// acquisition sequencer and register window
// ********************************************
// Notes on behaviour
// - reset clears the event counter
// - reset empties buffer, both pointers to zero
// - reset zeroes interrupt level and vector
// - reset sets chain base address to AA
// - idle trigger drives sections, counts event only with all-trigger bit set
// - accepted trigger raises busy until sequence end
// - abort during settling cancels, else sample all
// - accepted values stored between header and trailer
// - empty event, control low: nothing written
// - empty event, control high: header and trailer
// - sequence end clears sections and drops busy
// - set bit zero enables random buffer access
// - lower half write commits whole test word
// - setting test select locks load, starts replay
// - clearing test select flushes fifo, opens load
// - test trigger copies fifo as one event
// - empty buffer read gives filler or bus error
// - block end stops read after one trailer
// - 8-bit threshold against top eight value bits
// - discard bit set drops the channel
module mtd_acq #(
  parameter int AW   = 11, // buffer address width
  parameter int NCH  = 32, // channels
  parameter int TDEP = 32  // test fifo depth
) (
  // clock, enable, reset
  input  wire logic                         core_clk,
  input  wire logic                         ce,
  input  wire logic                         rst,
  // front pins, asynchronous
  input  wire logic                         trig_pin,
  input  wire logic                         abort_pin,
  // time_amplitude_section interface
  input  wire mtd_pkg::mtd_chan_t [NCH-1:0] sect_data,
  output logic                              sect_start,
  output logic                              sect_stop,
  output logic                              sect_clear,
  output logic                              busy,
  // register port
  input  wire mtd_pkg::mtd_bus_req_t        bus_req,
  output mtd_pkg::mtd_bus_rsp_t             bus_rsp,
  output logic                              test_fifo_ready
);
  localparam int DEPTH = 1 << AW;
  localparam int FCW   = $clog2(TDEP + 1);

  typedef struct packed {
    mtd_pkg::mtd_state_t          state;
    logic [7:0]                   cnt;     // settling countdown
    logic [5:0]                   idx;     // readout order index
    logic [DEPTH-1:0][31:0]       mem;     // multi_event_buffer
    logic [AW:0]                  wp;      // write pointer
    logic [AW:0]                  rp;      // read pointer
    logic [23:0]                  evcnt;   // event counter
    logic [2:0]                   ilvl;
    logic [7:0]                   ivec;
    logic [7:0]                   mcst;
    logic [7:0]                   crate;
    logic [15:0]                  bset2;
    logic [15:0]                  ctrl1;
    logic [15:0]                  twhi;    // held upper half
    logic [AW-1:0]                wta;
    logic [AW-1:0]                rta;
    logic [NCH-1:0][8:0]          thr;     // discard bit, threshold
    logic [NCH-1:0]               acc;     // accepted channels
    logic [5:0]                   nacc;    // event_word_count
    logic                         busy;
    logic                         start;
    logic                         stop;
    logic                         clr;
    logic [2:0]                   trg_s;   // sync pair plus edge tap
    logic [1:0]                   abt_s;   // sync pair
    logic                         blk_done;
    logic                         load;    // fifo open to host
    logic                         play;    // fifo replays on trigger
    logic                         pend;    // word to recirculate
    logic [15:0]                  pend_d;
    mtd_pkg::mtd_bus_rsp_t        rsp;
  } mtd_st_t;

  mtd_st_t r, n;

  // ********************************************
  // decode helpers
  // ********************************************
  function automatic logic mtd_hit(input logic [15:0] a,
                                   input logic [15:0] ofs);
    mtd_hit = (a == ofs);
  endfunction : mtd_hit

  // channel kept after discard, overflow and zero suppression
  function automatic logic mtd_keep(input mtd_pkg::mtd_chan_t c,
                                    input logic [8:0] t,
                                    input logic [15:0] b2);
    mtd_keep = !t[mtd_pkg::THR_KILL] &&
               (!c.ov || b2[mtd_pkg::B2_OVDIS]) &&
               (b2[mtd_pkg::B2_ZSDIS] || (c.val[11:4] > t[7:0]));
  endfunction : mtd_keep

  // accept vector, one comparator per channel
  logic [NCH-1:0] acc_w;
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_acc
      assign acc_w[gi] = mtd_keep(sect_data[gi], r.thr[gi], r.bset2);
    end
  endgenerate

  // ********************************************
  // test fifo hookup
  // ********************************************
  logic           f_in_valid, f_in_ready, f_out_valid, f_flush, pop;
  logic [15:0]    f_in_data, f_out_data;
  logic [FCW-1:0] f_count;
  logic           tev_wr;

  assign tev_wr     = bus_req.wr & mtd_hit(bus_req.addr, mtd_pkg::OFS_TEVW);
  assign f_in_valid = r.load ? tev_wr : r.pend;
  assign f_in_data  = r.load ? bus_req.wdata : r.pend_d;
  // clearing test select empties the fifo at once
  assign f_flush    = bus_req.wr & bus_req.wdata[mtd_pkg::B2_TESTACQ] &
                      mtd_hit(bus_req.addr, mtd_pkg::OFS_BCLR2);
  // replay pops while the data phase runs in test mode
  assign pop        = (r.state == mtd_pkg::MTD_DATA) & r.play &
                      r.bset2[mtd_pkg::B2_TESTACQ] & f_out_valid;
  assign test_fifo_ready = f_in_ready & r.load;

  mtd_fifo #(.W(16), .DEPTH(TDEP)) u_fifo (
    .core_clk (core_clk),
    .rst      (rst),
    .ce       (ce),
    .flush    (f_flush),
    .in_valid (f_in_valid),
    .in_ready (f_in_ready),
    .in_data  (f_in_data),
    .out_valid(f_out_valid),
    .out_ready(pop),
    .out_data (f_out_data),
    .count    (f_count)
  );

  assign sect_start = r.start;
  assign sect_stop  = r.stop;
  assign sect_clear = r.clr;
  assign busy       = r.busy;
  assign bus_rsp    = r.rsp;

  // ********************************************
  // next state
  // ********************************************
  always_comb begin
    logic [AW:0]  used;
    logic         full, trig, testm, wr, rd;
    logic [4:0]   ch;
    logic [5:0]   nw;
    logic [15:0]  a;
    logic [31:0]  word;
    n     = r;
    used  = r.wp - r.rp;
    full  = used > (AW + 1)'(DEPTH - mtd_pkg::EVT_MAX_WORDS);
    testm = r.bset2[mtd_pkg::B2_TESTACQ] & r.play;
    a     = bus_req.addr;
    wr    = bus_req.wr;
    rd    = bus_req.rd;
    ch    = {r.idx[0], r.idx[4:1]}; // order 0, 16, 1, 17 ...
    nw    = testm ? 6'(f_count) : r.nacc;
    word  = '0;
    n.start = 1'b0;
    n.stop  = 1'b0;
    n.clr   = 1'b0;
    n.pend  = 1'b0;
    n.trg_s = {r.trg_s[1:0], trig_pin};
    n.abt_s = {r.abt_s[0], abort_pin};
    trig    = (r.trg_s[1] & ~r.trg_s[2]) |
              (wr & mtd_hit(a, mtd_pkg::OFS_SWCOM));
    n.rsp   = '0;
    n.rsp.ack = wr | rd;
    if (!bus_req.blt) begin
      n.blk_done = 1'b0;
    end
    // register writes
    if (wr) begin
      if (mtd_hit(a, mtd_pkg::OFS_MCST))   n.mcst  = bus_req.wdata[7:0];
      if (mtd_hit(a, mtd_pkg::OFS_ILVL))   n.ilvl  = bus_req.wdata[2:0];
      if (mtd_hit(a, mtd_pkg::OFS_IVEC))   n.ivec  = bus_req.wdata[7:0];
      if (mtd_hit(a, mtd_pkg::OFS_CTRL1))  n.ctrl1 = bus_req.wdata;
      if (mtd_hit(a, mtd_pkg::OFS_CRATE))  n.crate = bus_req.wdata[7:0];
      if (mtd_hit(a, mtd_pkg::OFS_TWHI))   n.twhi  = bus_req.wdata;
      if (mtd_hit(a, mtd_pkg::OFS_WTADDR)) n.wta   = bus_req.wdata[AW-1:0];
      if (mtd_hit(a, mtd_pkg::OFS_RTADDR)) n.rta   = bus_req.wdata[AW-1:0];
      if (mtd_hit(a, mtd_pkg::OFS_EVRST))  n.evcnt = mtd_pkg::EVCNT_RST;
      if (a >= mtd_pkg::OFS_THR_LO && a <= mtd_pkg::OFS_THR_HI) begin
        n.thr[a[5:1]] = bus_req.wdata[8:0];
      end
      if (mtd_hit(a, mtd_pkg::OFS_BSET2)) begin
        n.bset2 = r.bset2 | bus_req.wdata;
        if (bus_req.wdata[mtd_pkg::B2_TESTACQ]) begin
          n.load = 1'b0; // write side locked, replay released
          n.play = 1'b1;
        end
      end
      if (mtd_hit(a, mtd_pkg::OFS_BCLR2)) begin
        n.bset2 = r.bset2 & ~bus_req.wdata;
        if (bus_req.wdata[mtd_pkg::B2_TESTACQ]) begin
          n.load = 1'b1; // back to normal, fifo open to loading
          n.play = 1'b0;
        end
      end
      // lower half commits the whole word in test mode
      if (mtd_hit(a, mtd_pkg::OFS_TWLO) && r.bset2[mtd_pkg::B2_MEMTEST]) begin
        n.mem[r.wta] = {r.twhi, bus_req.wdata};
      end
    end
    // register reads
    if (rd) begin
      if (a <= mtd_pkg::OFS_BUF_HI) begin
        if (r.bset2[mtd_pkg::B2_MEMTEST]) begin
          n.rsp.rdata = r.mem[r.rta];
        end else if (used == '0 || r.blk_done) begin
          // end of data: filler or bus error
          n.rsp.berr  = r.ctrl1[mtd_pkg::C1_BERR];
          n.rsp.rdata = {5'h00, mtd_pkg::WT_FILL, 24'h000000};
        end else begin
          n.rsp.rdata = r.mem[r.rp[AW-1:0]];
          n.rp        = r.rp + 1'b1;
          if (r.mem[r.rp[AW-1:0]][26:24] == mtd_pkg::WT_TRL &&
              r.ctrl1[mtd_pkg::C1_BLKEND] && bus_req.blt) begin
            n.blk_done = 1'b1;
          end
        end
      end
      else if (mtd_hit(a, mtd_pkg::OFS_MCST))  n.rsp.rdata = 32'(r.mcst);
      else if (mtd_hit(a, mtd_pkg::OFS_ILVL))  n.rsp.rdata = 32'(r.ilvl);
      else if (mtd_hit(a, mtd_pkg::OFS_IVEC))  n.rsp.rdata = 32'(r.ivec);
      else if (mtd_hit(a, mtd_pkg::OFS_CTRL1)) n.rsp.rdata = 32'(r.ctrl1);
      else if (mtd_hit(a, mtd_pkg::OFS_BSET2)) n.rsp.rdata = 32'(r.bset2);
      else if (mtd_hit(a, mtd_pkg::OFS_CRATE)) n.rsp.rdata = 32'(r.crate);
      else if (mtd_hit(a, mtd_pkg::OFS_EVCNT)) n.rsp.rdata = 32'(r.evcnt[15:0]);
      else if (mtd_hit(a, mtd_pkg::OFS_STAT)) begin
        n.rsp.rdata = {29'h0, full, r.busy, (used != '0)};
      end else if (a >= mtd_pkg::OFS_THR_LO && a <= mtd_pkg::OFS_THR_HI) begin
        n.rsp.rdata = 32'(r.thr[a[5:1]]);
      end
    end
    // sequencer
    case (r.state)
      mtd_pkg::MTD_IDLE: begin
        if (trig) begin // busy triggers never reach here
          n.busy  = 1'b1;
          n.stop  = r.bset2[mtd_pkg::B2_STOPMODE];
          n.start = ~r.bset2[mtd_pkg::B2_STOPMODE];
          n.cnt   = 8'(mtd_pkg::CONV_CYC);
          if (r.bset2[mtd_pkg::B2_ALLTRG]) n.evcnt = r.evcnt + 1'b1;
          n.state = mtd_pkg::MTD_CONV;
        end
      end
      mtd_pkg::MTD_CONV: begin
        n.cnt = r.cnt - 1'b1;
        if (r.abt_s[1]) begin
          n.clr   = 1'b1; // event cancelled
          n.busy  = 1'b0;
          n.state = mtd_pkg::MTD_IDLE;
        end else if (r.cnt == 8'h01) begin
          n.state = mtd_pkg::MTD_SAMP;
        end
      end
      mtd_pkg::MTD_SAMP: begin
        n.acc  = acc_w; // accept flags of all channels sampled at once
        n.nacc = '0;
        for (int i = 0; i < NCH; i++) n.nacc = n.nacc + 6'(acc_w[i]);
        n.state = mtd_pkg::MTD_HDR;
      end
      mtd_pkg::MTD_HDR: begin
        n.idx = '0;
        if (nw == '0 && !r.bset2[mtd_pkg::B2_EMPTY]) begin
          n.clr   = 1'b1; // nothing stored
          n.state = mtd_pkg::MTD_DONE;
        end else begin
          n.mem[r.wp[AW-1:0]] = {5'h00, mtd_pkg::WT_HDR, r.crate,
                                 2'b00, nw, 8'h00};
          n.wp    = r.wp + 1'b1;
          if (!r.bset2[mtd_pkg::B2_ALLTRG]) n.evcnt = r.evcnt + 1'b1;
          n.state = (nw == '0) ? mtd_pkg::MTD_TRL : mtd_pkg::MTD_DATA;
        end
      end
      mtd_pkg::MTD_DATA: begin
        n.idx = r.idx + 1'b1;
        if (testm) begin
          if (f_out_valid) begin // same order as loaded
            word   = {5'h00, mtd_pkg::WT_DATA, 3'h0, ch, 3'h0,
                      f_out_data[12], f_out_data[11:0]};
            n.mem[r.wp[AW-1:0]] = word;
            n.wp     = r.wp + 1'b1;
            n.pend   = 1'b1; // put the word back for the next event
            n.pend_d = f_out_data;
          end
          if (!f_out_valid || r.idx == 6'(NCH - 1)) begin
            n.state = mtd_pkg::MTD_TRL;
          end
        end else begin
          if (r.acc[ch]) begin
            word = {5'h00, mtd_pkg::WT_DATA, 3'h0, ch, 3'h0,
                    sect_data[ch].ov, sect_data[ch].val};
            n.mem[r.wp[AW-1:0]] = word;
            n.wp = r.wp + 1'b1;
          end
          if (r.idx == 6'(NCH - 1)) n.state = mtd_pkg::MTD_TRL;
        end
      end
      mtd_pkg::MTD_TRL: begin
        n.mem[r.wp[AW-1:0]] = {5'h00, mtd_pkg::WT_TRL, r.evcnt};
        n.wp    = r.wp + 1'b1;
        n.clr   = 1'b1;
        n.state = mtd_pkg::MTD_DONE;
      end
      mtd_pkg::MTD_DONE: begin
        if (!full) begin // busy held while the buffer is full
          n.busy  = 1'b0;
          n.state = mtd_pkg::MTD_IDLE;
        end
      end
      default: n.state = mtd_pkg::MTD_IDLE;
    endcase
  end

  // register the state; synchronous reset is the power-up state
  always_ff @(posedge core_clk) begin
    if (rst) begin
      r       <= '0;
      r.state <= mtd_pkg::MTD_IDLE;
      r.evcnt <= mtd_pkg::EVCNT_RST;
      r.ilvl  <= mtd_pkg::ILVL_RST;
      r.ivec  <= mtd_pkg::IVEC_RST;
      r.mcst  <= mtd_pkg::MCST_RST;
      r.load  <= 1'b1;
    end else if (ce) begin
      r <= n;
    end
  end
endmodule : mtd_acq

// [mtd_pkg.sv]
/*
  shared constants, field layouts and carrier types of the multievent
  time digitiser acquisition control.
  assumes a 16-bit register window addressed by byte offset and a
  32-bit wide readout of the multi_event_buffer.
*/
package mtd_pkg;

  // ********************************************
  // register offsets
  // ********************************************
  localparam logic [15:0] OFS_BUF_LO = 16'h0000; // buffer readout window
  localparam logic [15:0] OFS_BUF_HI = 16'h0FFC;
  localparam logic [15:0] OFS_MCST   = 16'h1004; // chain/broadcast base
  localparam logic [15:0] OFS_ILVL   = 16'h100A; // interrupt level
  localparam logic [15:0] OFS_IVEC   = 16'h100C; // interrupt vector
  localparam logic [15:0] OFS_STAT   = 16'h100E; // status, read only
  localparam logic [15:0] OFS_CTRL1  = 16'h1010; // readout control
  localparam logic [15:0] OFS_EVCNT  = 16'h1024; // event counter low
  localparam logic [15:0] OFS_BSET2  = 16'h1032; // second set-bit reg
  localparam logic [15:0] OFS_BCLR2  = 16'h1034; // second clear-bit reg
  localparam logic [15:0] OFS_WTADDR = 16'h1036; // test write address
  localparam logic [15:0] OFS_TWHI   = 16'h1038; // test word upper half
  localparam logic [15:0] OFS_TWLO   = 16'h103A; // test word lower half
  localparam logic [15:0] OFS_CRATE  = 16'h103C; // crate number
  localparam logic [15:0] OFS_TEVW   = 16'h103E; // test_event_fifo_write
  localparam logic [15:0] OFS_EVRST  = 16'h1040; // event counter clear
  localparam logic [15:0] OFS_RTADDR = 16'h1064; // test read address
  localparam logic [15:0] OFS_SWCOM  = 16'h1068; // software trigger
  localparam logic [15:0] OFS_THR_LO = 16'h1080; // first threshold
  localparam logic [15:0] OFS_THR_HI = 16'h10BE; // last threshold

  // ********************************************
  // field positions
  // ********************************************
  localparam int B2_MEMTEST  = 0;  // random buffer access test
  localparam int B2_OVDIS    = 3;  // keep overflowed values
  localparam int B2_ZSDIS    = 4;  // keep values under threshold
  localparam int B2_VALID    = 5;  // valid-data check control
  localparam int B2_TESTACQ  = 6;  // acquisition_test_select
  localparam int B2_STOPMODE = 10; // trigger stops the sections
  localparam int B2_EMPTY    = 12; // empty_event_write_ctl
  localparam int B2_ALLTRG   = 14; // count every accepted trigger
  localparam int C1_BLKEND   = 2;  // stop block read at trailer
  localparam int C1_BERR     = 5;  // bus_error_on_end_enable
  localparam int THR_KILL    = 8;  // discard bit above threshold

  // ********************************************
  // reset values and word types
  // ********************************************
  localparam logic [7:0]  MCST_RST  = 8'hAA;
  localparam logic [2:0]  ILVL_RST  = 3'h0;
  localparam logic [7:0]  IVEC_RST  = 8'h00;
  localparam logic [23:0] EVCNT_RST = 24'h000000;
  localparam logic [2:0]  WT_DATA   = 3'h0;
  localparam logic [2:0]  WT_HDR    = 3'h2;
  localparam logic [2:0]  WT_TRL    = 3'h4;
  localparam logic [2:0]  WT_FILL   = 3'h6;

  // ********************************************
  // timing
  // ********************************************
  localparam int CLK_NS        = 100;  // core_clk period
  localparam int CONV_NS       = 5700; // section settle time, least
  localparam int CONV_CYC      = (CONV_NS + CLK_NS - 1) / CLK_NS;
  localparam int EVT_MAX_WORDS = 34;   // header, 32 data, trailer

  // ********************************************
  // carrier types
  // ********************************************
  typedef struct packed {
    logic        wr;    // one-cycle write strobe
    logic        rd;    // one-cycle read strobe
    logic        blt;   // high for the whole block transfer
    logic [15:0] addr;  // byte offset
    logic [15:0] wdata; // write data
  } mtd_bus_req_t;

  typedef struct packed {
    logic        ack;   // one cycle after the strobe
    logic        berr;  // with ack, bus error answer
    logic [31:0] rdata; // read data
  } mtd_bus_rsp_t;

  typedef struct packed {
    logic        ov;    // overflow_flag
    logic [11:0] val;   // converted value
  } mtd_chan_t;

  typedef enum logic [2:0] {
    MTD_IDLE = 3'h0,
    MTD_CONV = 3'h1,
    MTD_SAMP = 3'h3,
    MTD_HDR  = 3'h2,
    MTD_DATA = 3'h6,
    MTD_TRL  = 3'h7,
    MTD_DONE = 3'h5
  } mtd_state_t;

endpackage : mtd_pkg

// [mtd_acq_assertions.sv]
/* checker for the acquisition control ports.
   assumes one core_clk domain and sync active-high rst. */
`timescale 1ns/1ps
module mtd_acq_chk #(parameter int NCH = 32) (
  // clock, reset, front pins
  input wire logic core_clk, ce, rst, trig_pin, abort_pin,
  // section side
  input wire mtd_pkg::mtd_chan_t [NCH-1:0] sect_data,
  input wire logic sect_start, sect_stop, sect_clear, busy,
  // register port
  input wire mtd_pkg::mtd_bus_req_t bus_req,
  input wire mtd_pkg::mtd_bus_rsp_t bus_rsp,
  input wire logic test_fifo_ready
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  a_reset_quiet: assert property (
    $fell(rst) |-> !busy && !bus_rsp.ack)
    else $error("outputs active after reset");
  a_ack_follows: assert property (
    ce && (bus_req.wr || bus_req.rd) |=> bus_rsp.ack)
    else $error("request not answered");
  a_ack_cause: assert property (
    bus_rsp.ack |-> $past(bus_req.wr) || $past(bus_req.rd))
    else $error("answer without request");
  a_berr_ack: assert property (bus_rsp.berr |-> bus_rsp.ack)
    else $error("bus error without ack");
  a_start_busy: assert property (
    $rose(busy) |-> sect_start || sect_stop)
    else $error("busy without start");
  a_start_excl: assert property (!(sect_start && sect_stop))
    else $error("start and stop together");
  a_busy_ignores: assert property (
    busy && $past(busy) |-> !sect_start)
    else $error("restart while busy");
  a_busy_held: assert property (disable iff (rst || abort_pin)
    sect_start |-> busy [*8])
    else $error("busy dropped early");
  a_busy_bounded: assert property (sect_start |-> ##[1:120] !busy)
    else $error("busy stuck");
  a_clear_end: assert property ($fell(busy) |->
    sect_clear || $past(sect_clear) || $past(sect_clear, 2))
    else $error("sections not cleared");
  c_start: cover property (sect_start);
  c_stop: cover property (sect_stop);
  c_berr: cover property (bus_rsp.berr);
  c_fifo_full: cover property (!test_fifo_ready);
endmodule : mtd_acq_chk
bind mtd_acq mtd_acq_chk #(.NCH(NCH)) u_chk (.core_clk(core_clk), .ce(ce),
  .rst(rst), .trig_pin(trig_pin), .abort_pin(abort_pin),
  .sect_data(sect_data), .sect_start(sect_start), .sect_stop(sect_stop),
  .sect_clear(sect_clear), .busy(busy), .bus_req(bus_req),
  .bus_rsp(bus_rsp), .test_fifo_ready(test_fifo_ready));

// [mtd_host_model.sv]
/* host side bus master for the register port.
   assumes one-cycle strobes and ack within three cycles. */
`timescale 1ns/1ps
module mtd_host_model (
  // clock
  input wire logic core_clk,
  // register port
  output mtd_pkg::mtd_bus_req_t req,
  input wire mtd_pkg::mtd_bus_rsp_t rsp
);
  initial req = '0;
  // one transfer; released lines flip so stale data never matches
  task automatic xfer(input logic w, input logic [15:0] a, d,
                      output logic [31:0] q, output logic e);
    int i;
    @(negedge core_clk);
    req.wr = w;
    req.rd = !w;
    req.addr = a;
    req.wdata = d;
    @(negedge core_clk);
    req.wr = 1'b0;
    req.rd = 1'b0;
    req.addr = ~a;
    req.wdata = ~d;
    for (i = 0; i < 3 && rsp.ack !== 1'b1; i++) @(negedge core_clk);
    q = rsp.rdata;
    e = rsp.berr;
  endtask : xfer
  // blt held over a run of reads
  task automatic set_blt(input logic b);
    req.blt = b;
  endtask : set_blt
endmodule : mtd_host_model

// [mtd_acq_tb_top.sv]
/* self-checking bench for the acquisition control.
   assumes the host model for bus cycles; inputs move on falling edge. */
`timescale 1ns/1ps
module mtd_acq_tb_top;
  logic core_clk = 0, rst = 1, trig_pin = 0, abort_pin = 0;
  logic s_start, s_stop, s_clr, busy, tfr, e;
  mtd_pkg::mtd_chan_t [31:0] sd = '0;
  mtd_pkg::mtd_bus_req_t req;
  mtd_pkg::mtd_bus_rsp_t rsp;
  logic [31:0] q;
  int error_cnt = 0, compares = 0, cyc = 0;
  mtd_acq u_dut (.core_clk(core_clk), .ce(1'b1), .rst(rst),
    .trig_pin(trig_pin), .abort_pin(abort_pin), .sect_data(sd),
    .sect_start(s_start), .sect_stop(s_stop), .sect_clear(s_clr),
    .busy(busy), .bus_req(req), .bus_rsp(rsp), .test_fifo_ready(tfr));
  mtd_host_model u_host (.core_clk(core_clk), .req(req), .rsp(rsp));
  initial forever #50 core_clk = ~core_clk;
  // hang guard, far above the expected run
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    compares++;
    if (s !== x) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, x);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    u_host.xfer(1'b1, a, d, q, e);
  endtask : wr
  task automatic rd(input logic [15:0] a);
    u_host.xfer(1'b0, a, 16'h0000, q, e);
  endtask : rd
  // trigger, then a second pulse while busy that must be ignored
  task automatic trig();
    int i;
    @(negedge core_clk) trig_pin = 1;
    repeat (6) @(negedge core_clk);
    chk(32'(busy), 32'h1);
    trig_pin = 0;
    repeat (3) @(negedge core_clk);
    trig_pin = 1;
    repeat (3) @(negedge core_clk);
    trig_pin = 0;
    for (i = 0; i < 200 && busy !== 1'b0; i++) @(negedge core_clk);
  endtask : trig
  task automatic do_reset();
    @(negedge core_clk) rst = 1;
    repeat (10) @(negedge core_clk);
    rst = 0;
  endtask : do_reset
  task automatic t_reset();
    rd(mtd_pkg::OFS_MCST);
    chk(32'(q[7:0]), 32'hAA);
    rd(mtd_pkg::OFS_ILVL);
    chk(32'(q[2:0]), 32'h0);
    rd(mtd_pkg::OFS_IVEC);
    chk(32'(q[7:0]), 32'h0);
    rd(mtd_pkg::OFS_EVCNT);
    chk(32'(q[15:0]), 32'h0);
    rd(16'h0000);
    chk(q, 32'h06000000);
  endtask : t_reset
  task automatic t_normal();
    int c;
    logic [4:0] ch;
    wr(mtd_pkg::OFS_CRATE, 16'h0005);
    for (c = 0; c < 32; c++) begin
      sd[c] = {1'b0, 12'(12'h100 + c)};
      wr(16'(mtd_pkg::OFS_THR_LO + 2 * c), c == 3 ? 16'h0100 :
         c == 5 ? 16'h0010 : 16'h0000);
    end
    trig();
    rd(16'h0000);
    chk(q, 32'h02051E00);
    for (c = 0; c < 32; c++) begin
      ch = 5'(c / 2 + 16 * (c % 2));
      if (ch != 3 && ch != 5) begin
        rd(16'h0000);
        chk(q, {11'h0, ch, 4'h0, 12'(12'h100 + ch)});
      end
    end
    rd(16'h0000);
    chk(q, 32'h04000001);
    rd(mtd_pkg::OFS_EVCNT);
    chk(32'(q[15:0]), 32'h1);
  endtask : t_normal
  task automatic t_abort();
    @(negedge core_clk) trig_pin = 1;
    repeat (10) @(negedge core_clk);
    abort_pin = 1;
    trig_pin = 0;
    repeat (6) @(negedge core_clk);
    chk(32'(busy), 32'h0);
    abort_pin = 0;
    rd(16'h0000);
    chk(q, 32'h06000000);
  endtask : t_abort
  task automatic t_empty();
    sd = '0;
    trig();
    rd(16'h0000);
    chk(q, 32'h06000000);
    wr(mtd_pkg::OFS_BSET2, 16'h1400);
    trig();
    rd(16'h0000);
    chk(q, 32'h02050000);
    rd(16'h0000);
    chk(q, 32'h04000002);
    wr(mtd_pkg::OFS_BCLR2, 16'h1400);
  endtask : t_empty
  task automatic t_block();
    int i;
    for (i = 0; i < 32; i++) sd[i] = {1'b0, 12'h100};
    wr(mtd_pkg::OFS_CTRL1, 16'h0024);
    trig();
    trig();
    u_host.set_blt(1'b1);
    for (i = 0; i < 33; i++) rd(16'h0000);
    chk(32'(e), 32'h1);
    u_host.set_blt(1'b0);
    wr(mtd_pkg::OFS_CTRL1, 16'h0020);
    for (i = 0; i < 33; i++) rd(16'h0000);
    chk(32'(e), 32'h1);
    wr(mtd_pkg::OFS_CTRL1, 16'h0000);
    rd(16'h0000);
    chk({q[31:1], e}, 32'h06000000);
  endtask : t_block
  task automatic t_memtest();
    wr(mtd_pkg::OFS_BSET2, 16'h0001);
    wr(mtd_pkg::OFS_WTADDR, 16'h0005);
    wr(mtd_pkg::OFS_TWHI, 16'h1234);
    wr(mtd_pkg::OFS_TWLO, 16'h5678);
    wr(mtd_pkg::OFS_WTADDR, 16'h0006);
    wr(mtd_pkg::OFS_RTADDR, 16'h0005);
    rd(16'h0000);
    chk(q, 32'h12345678);
    wr(mtd_pkg::OFS_BCLR2, 16'h0001);
  endtask : t_memtest
  task automatic t_testacq();
    int i;
    do_reset();
    wr(mtd_pkg::OFS_BSET2, 16'h0020);
    wr(mtd_pkg::OFS_BSET2, 16'h0040);
    wr(mtd_pkg::OFS_BCLR2, 16'h0040);
    chk(32'(tfr), 32'h1);
    for (i = 0; i < 32; i++) wr(mtd_pkg::OFS_TEVW, 16'(i + 1));
    chk(32'(tfr), 32'h0);
    wr(mtd_pkg::OFS_BSET2, 16'h0040);
    trig();
    rd(16'h0000);
    chk(32'(q[13:8]), 32'h20);
    for (i = 0; i < 32; i++) begin
      rd(16'h0000);
      chk(32'(q[12:0]), 32'(i + 1));
    end
  endtask : t_testacq
  initial begin
    do_reset();
    t_reset();
    t_normal();
    t_abort();
    t_empty();
    t_block();
    t_memtest();
    t_testacq();
    stop_test();
  end
endmodule : mtd_acq_tb_top
